//--- common/cio_pkg.sv
// Constants shared by the instruction execution core and its result unit.
// Assumes one 20 MHz core clock and an APB master with 32-bit data.
//
// Operation
// [RULE1] Zero-accumulator op writes zero to the accumulator and sets zero flag.
// [RULE2] Call first pushes program counter plus one onto the return stack.
// [RULE3] Call loads its 8-bit target, 0 to 255, into program counter bits 7:0.
// [RULE4] Call copies status bits 6:5 to counter bits 10:9, clears bit 8.
// [RULE5] Call takes two instruction cycles and changes no status flag.
// [RULE6] Kick-watchdog op takes no operands and zeroes the watchdog counter.
// [RULE7] Kick-watchdog op also zeroes the prescaler when assigned to the watchdog.
// [RULE8] Kick-watchdog op sets timeout and powerdown flags, no other flags.
// [RULE9] Zero-file-register op zeroes file register 0 to 31, sets zero flag.
// [RULE10] Invert op complements file register; dest 0 to accumulator, 1 to file.
// [RULE11] Minus-one op decrements file register; dest 0 accumulator, 1 file.
// [RULE12] Plus-one op increments file register; dest 0 accumulator, 1 file.
// [RULE13] Invert, minus and plus set zero flag on zero result, keep carries.
// [RULE14] All other ops take one instruction cycle; counts wrap modulo 256.
package cio_pkg;

    // Register byte offsets on the APB.
    localparam logic [7:0] ADDR_INSTR     = 8'h00;
    localparam logic [7:0] ADDR_ACC       = 8'h04;
    localparam logic [7:0] ADDR_STATUS    = 8'h08;
    localparam logic [7:0] ADDR_PC        = 8'h0C;
    localparam logic [7:0] ADDR_WDOG      = 8'h10;
    localparam logic [7:0] ADDR_CFG       = 8'h14;
    localparam logic [7:0] ADDR_STACK     = 8'h18;
    localparam int         FILE_BASE_BIT  = 7;

    // Instruction word fields.
    localparam int INSTR_W   = 12;
    localparam int K_LSB     = 0;
    localparam int K_W       = 8;
    localparam int FADDR_W   = 5;
    localparam int DEST_BIT  = 8;
    localparam int OP_LSB    = 9;
    localparam int OP_W      = 3;
    localparam int BUSY_BIT  = 31;

    // Operation codes.
    localparam logic [OP_W-1:0] OP_ZERO_ACC  = 3'h0;
    localparam logic [OP_W-1:0] OP_CALL      = 3'h1;
    localparam logic [OP_W-1:0] OP_KICK_WDOG = 3'h2;
    localparam logic [OP_W-1:0] OP_ZERO_FILE = 3'h3;
    localparam logic [OP_W-1:0] OP_INVERT    = 3'h4;
    localparam logic [OP_W-1:0] OP_MINUS_ONE = 3'h5;
    localparam logic [OP_W-1:0] OP_PLUS_ONE  = 3'h6;
    localparam logic [OP_W-1:0] OP_NOP       = 3'h7;

    // Status register bit positions.
    localparam int ST_CARRY     = 0;
    localparam int ST_DCARRY    = 1;
    localparam int ST_ZERO      = 2;
    localparam int ST_POWERDOWN = 3;
    localparam int ST_TIMEOUT   = 4;
    localparam int ST_PAGE_LSB  = 5;
    localparam int ST_PAGE_MSB  = 6;

    // Configuration bit positions.
    localparam int CFG_PSC_TO_WDOG = 0;
    localparam int CFG_WDOG_EN     = 1;

    // Values after reset.
    localparam logic [7:0]  STATUS_RST = 8'h18;
    localparam logic [1:0]  CFG_RST    = 2'h3;
    localparam logic [10:0] PC_RST     = 11'h000;

    // Timing: instruction cycle against the core clock.
    localparam int CLK_PERIOD_NS  = 50;
    localparam int INSTR_CYCLE_NS = 200;
    localparam int INSTR_CLKS     = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CALL_CYCLES    = 2;
    localparam int SINGLE_CYCLES  = 1;
    localparam int CNT_W          = 4;
    localparam logic [CNT_W-1:0] CALL_LOAD   = CNT_W'(CALL_CYCLES * INSTR_CLKS - 1);
    localparam logic [CNT_W-1:0] SINGLE_LOAD = CNT_W'(SINGLE_CYCLES * INSTR_CLKS - 1);

endpackage

//--- logic/cio_file_alu.sv
// Result unit for the file-register operations of the execution core.
// Assumes the operand is the addressed file register, read in the same cycle.
`timescale 1ns/100ps
module cio_file_alu
    import cio_pkg::*;
(
    input  wire logic [OP_W-1:0] op,
    input  wire logic [7:0]      operand,
    output logic      [7:0]      result,
    output logic                 zero
);

    // Computes the 8-bit result; the sums are cut to eight bits so they wrap.
    always_comb
    begin
        result = operand;
        unique case (op)
            OP_INVERT:    result = ~operand;               // RULE10
            OP_MINUS_ONE: result = 8'(operand - 8'h01);    // RULE11 RULE14
            OP_PLUS_ONE:  result = 8'(operand + 8'h01);    // RULE12 RULE14
            OP_ZERO_FILE: result = 8'h00;                  // RULE9
            default:      result = operand;
        endcase
    end

    // Zero flag follows the result.
    assign zero = (result == 8'h00); // RULE13

endmodule

//--- logic/cio_exec_core.sv
// Execution core for the clear, call, watchdog-kick and increment group.
// Instructions arrive one at a time as a word written over APB.
// Assumes an APB master on pclk; software writes one instruction at a time.
`timescale 1ns/100ps
module cio_exec_core
    import cio_pkg::*;
#(
    parameter int STACK_DEPTH = 4,
    parameter int PSC_W       = 8,
    parameter int WDOG_W      = 8
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [10:0] program_counter,
    output logic             exec_busy
);

    localparam int DEPTH_W = $clog2(STACK_DEPTH + 1);

    // Architectural state. The file registers and the return stack are small
    // enough to live in flops here, so every location resets to zero and a
    // read never returns an unknown value.
    logic [7:0]         acc_q;
    logic [7:0]         status_q;
    logic [10:0]        pc_q;
    logic [INSTR_W-1:0] instr_q;
    logic               busy_q;
    logic [CNT_W-1:0]   cnt_q;
    logic [7:0]         file_q  [32];
    logic [10:0]        stack_q [STACK_DEPTH];
    logic [DEPTH_W-1:0] depth_q;
    logic [WDOG_W-1:0]  watchdog_counter_q;
    logic [PSC_W-1:0]   presc_q;
    logic [1:0]         cfg_q;
    logic [31:0]        prdata_q;
    logic               slverr_q;

    // Bus decode. The file window sits above the fixed registers, so one
    // address bit separates the two halves of the map.
    // Exact compares keep each fixed register at a single address.
    logic               setup;
    logic               access;
    logic               wr_fire;
    logic               hit_instr;
    logic               hit_acc;
    logic               hit_status;
    logic               hit_pc;
    logic               hit_wdog;
    logic               hit_cfg;
    logic               hit_stack;
    logic               hit_file;
    logic               mapped;
    logic [4:0]         file_idx;
    logic [31:0]        rd_mux;

    // Execution decode. All fields come from the latched word, so software may
    // change the bus inputs freely while an instruction is still running.
    logic               commit;
    logic [OP_W-1:0]    op;
    logic               dest_file;
    logic [7:0]         lit_k;
    logic [FADDR_W-1:0] faddr;
    logic               file_op;
    logic [7:0]         alu_result;
    logic               alu_zero;
    logic               wdog_tick;
    logic               wdog_wrap;
    logic               kick;
    logic [10:0]        pc_next;

    // Phase and address decode; offsets are word aligned. A byte address with
    // either low bit set never matches, so it falls into the error case.
    assign setup      = psel & ~penable;
    assign access     = psel & penable;
    assign wr_fire    = access & pwrite & pready;
    assign file_idx   = paddr[6:2];
    assign hit_file   = paddr[FILE_BASE_BIT] & (paddr[1:0] == 2'h0);
    assign hit_instr  = (paddr == ADDR_INSTR);
    assign hit_acc    = (paddr == ADDR_ACC);
    assign hit_status = (paddr == ADDR_STATUS);
    assign hit_pc     = (paddr == ADDR_PC);
    assign hit_wdog   = (paddr == ADDR_WDOG);
    assign hit_cfg    = (paddr == ADDR_CFG);
    assign hit_stack  = (paddr == ADDR_STACK);
    assign mapped     = hit_file | hit_instr | hit_acc | hit_status | hit_pc
                      | hit_wdog | hit_cfg | hit_stack;

    // Writes wait while an instruction runs so no store races the result.
    // Reads are never held: they see the state as it stood before the commit.
    // Keeping pready off the address decode keeps it a short path for masters.
    assign pready  = ~(pwrite & busy_q);
    assign pslverr = access & pready & slverr_q;
    assign prdata  = prdata_q;

    // Instruction fields of the latched word.
    // The commit strobe is the single cycle in which results become visible;
    // every execution result below keys off it.
    assign op        = instr_q[OP_LSB +: OP_W];
    assign dest_file = instr_q[DEST_BIT];
    assign lit_k     = instr_q[K_LSB +: K_W];
    assign faddr     = instr_q[K_LSB +: FADDR_W];
    assign file_op   = (op == OP_INVERT) | (op == OP_MINUS_ONE) | (op == OP_PLUS_ONE);
    assign commit    = busy_q & (cnt_q == '0);
    assign kick      = commit & (op == OP_KICK_WDOG);
    assign pc_next   = 11'(pc_q + 11'h001);

    // Result unit reads the addressed file register.
    // Its answer is used only in the commit cycle, when the address is settled.
    // The unit is purely combinational and holds no state of its own.
    cio_file_alu cio_file_alu_inst
    (
        .op      (op),
        .operand (file_q[faddr]),
        .result  (alu_result),
        .zero    (alu_zero)
    );

    // Read data mux; unmapped locations read zero.
    // The watchdog counter and the stack are read only; a write to them is
    // accepted without error and has no effect.
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit_file)
            rd_mux[7:0] = file_q[file_idx];
        else if (hit_instr)
        begin
            rd_mux[INSTR_W-1:0] = instr_q;
            rd_mux[BUSY_BIT]    = busy_q;
        end
        else if (hit_acc)
            rd_mux[7:0] = acc_q;
        else if (hit_status)
            rd_mux[7:0] = status_q;
        else if (hit_pc)
            rd_mux[10:0] = pc_q;
        else if (hit_wdog)
            rd_mux[WDOG_W-1:0] = watchdog_counter_q;
        else if (hit_cfg)
            rd_mux[1:0] = cfg_q;
        else if (hit_stack)
        begin
            rd_mux[10:0]            = stack_q[0];
            rd_mux[16 +: DEPTH_W]   = depth_q;
        end
    end

    // Read data and error are captured in the setup cycle and held for access.
    // Capturing early lets reads finish with no wait state, at the cost of
    // returning the value as it stood one cycle before the access phase.
    // Write data is not returned; a write reads back zero.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end
        else if (setup)
        begin
            prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
            slverr_q <= ~mapped;
        end
    end

    // Instruction latch and cycle counter; call runs two instruction cycles.
    // One instruction cycle is four core clocks, so the counter starts at three
    // for a single-cycle op and at seven for a call. A new instruction cannot
    // arrive while busy because writes are stalled until the commit.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            instr_q <= '0;
            busy_q  <= 1'b0;
            cnt_q   <= '0;
        end
        else if (wr_fire & hit_instr)
        begin
            instr_q <= pwdata[INSTR_W-1:0];
            busy_q  <= 1'b1;
            if (pwdata[OP_LSB +: OP_W] == OP_CALL)
                cnt_q <= CALL_LOAD;   // RULE5
            else
                cnt_q <= SINGLE_LOAD; // RULE14
        end
        else if (commit)
            busy_q <= 1'b0;
        else if (busy_q)
            cnt_q <= cnt_q - 1'b1;
    end

    // Accumulator: cleared, loaded from the result unit, or written by software.
    // Execution and software never collide here since writes stall while busy.
    // Only one of the execution branches can be true in a commit cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            acc_q <= 8'h00;
        else if (commit & (op == OP_ZERO_ACC))
            acc_q <= 8'h00;                 // RULE1
        else if (commit & file_op & ~dest_file)
            acc_q <= alu_result;            // RULE10 RULE11 RULE12
        else if (wr_fire & hit_acc)
            acc_q <= pwdata[7:0];
    end

    // File registers: cleared or written back when the destination bit is one.
    // Only the addressed entry changes; the other registers keep their contents.
    // A zero op and a write-back are exclusive, being different codes.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 32; i++)
                file_q[i] <= 8'h00;
        end
        else if (commit & (op == OP_ZERO_FILE))
            file_q[faddr] <= 8'h00;         // RULE9
        else if (commit & file_op & dest_file)
            file_q[faddr] <= alu_result;    // RULE10 RULE11 RULE12
        else if (wr_fire & hit_file)
            file_q[file_idx] <= pwdata[7:0];
    end

    // Status flags. A watchdog wrap clears timeout and wins over a software write.
    // The zero flag follows the op that commits; carry and digit carry are
    // never touched by this group, and a call leaves every flag alone.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            status_q <= STATUS_RST;
        else
        begin
            if (wr_fire & hit_status)
                status_q <= pwdata[7:0];
            if (commit & ((op == OP_ZERO_ACC) | (op == OP_ZERO_FILE)))
                status_q[ST_ZERO] <= 1'b1;  // RULE1 RULE9
            if (commit & file_op)
                status_q[ST_ZERO] <= alu_zero; // RULE13
            if (kick)
            begin
                status_q[ST_TIMEOUT]   <= 1'b1; // RULE8
                status_q[ST_POWERDOWN] <= 1'b1; // RULE8
            end
            else if (wdog_wrap)
                status_q[ST_TIMEOUT] <= 1'b0;
        end
    end

    // Program counter: advances once per instruction, or jumps on a call.
    // A call keeps its page from the status bits and always lands in the lower
    // half of that page, since bit eight is forced low.
    // Software may load the counter only while no instruction runs.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pc_q <= PC_RST;
        else if (commit & (op == OP_CALL))
            pc_q <= {status_q[ST_PAGE_MSB:ST_PAGE_LSB], 1'b0, lit_k}; // RULE3 RULE4
        else if (commit)
            pc_q <= pc_next;
        else if (wr_fire & hit_pc)
            pc_q <= pwdata[10:0];
    end

    // Return stack: a call pushes the next address; the oldest entry falls off.
    // The depth saturates, so a program that nests too deeply silently loses
    // its oldest return address rather than raising an error.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < STACK_DEPTH; i++)
                stack_q[i] <= 11'h000;
            depth_q <= '0;
        end
        else if (commit & (op == OP_CALL))
        begin
            for (int i = STACK_DEPTH - 1; i > 0; i--)
                stack_q[i] <= stack_q[i-1];
            stack_q[0] <= pc_next;          // RULE2
            if (depth_q != DEPTH_W'(STACK_DEPTH))
                depth_q <= depth_q + 1'b1;
        end
    end

    // Configuration: prescaler assignment and watchdog enable.
    // Both bits come out of reset set, so the watchdog runs from power-up.
    // Software writes them at any time outside execution.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cfg_q <= CFG_RST;
        else if (wr_fire & hit_cfg)
            cfg_q <= pwdata[1:0];
    end

    // Watchdog steps on each prescaler wrap when assigned, else every clock.
    // With the prescaler on the timer side the watchdog runs undivided here.
    assign wdog_tick = cfg_q[CFG_WDOG_EN]
                     & (~cfg_q[CFG_PSC_TO_WDOG] | (presc_q == '1));
    assign wdog_wrap = wdog_tick & (watchdog_counter_q == '1) & ~kick;

    // Shared prescaler; a kick clears it only while it serves the watchdog.
    // It free-runs in both assignments; clearing it while it serves the timer
    // would disturb the timer's period.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            presc_q <= '0;
        else if (kick & cfg_q[CFG_PSC_TO_WDOG])
            presc_q <= '0;                  // RULE7
        else
            presc_q <= presc_q + 1'b1;
    end

    // Watchdog counter; the kick wins over a tick in the same cycle.
    // A wrap is masked by the kick as well, so a late kick still saves timeout.
    // Its width is a parameter, so the time-out period scales with it.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            watchdog_counter_q <= '0;
        else if (kick)
            watchdog_counter_q <= '0;       // RULE6
        else if (wdog_tick)
            watchdog_counter_q <= watchdog_counter_q + 1'b1;
    end

    // Visible execution state.
    // Both outputs come straight from flops, so they are glitch free.
    // Software may poll exec_busy instead of reading the instruction word.
    assign program_counter = pc_q;
    assign exec_busy       = busy_q;

endmodule

//--- verif/cio_exec_assertions.sv
// Checker for the execution core: busy timing and program-counter results.
// Assumes it is bound to cio_exec_core and sees only that module's ports.
`timescale 1ns/100ps
module cio_exec_checker
    import cio_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [10:0] program_counter,
    input wire logic        exec_busy
);
    logic            take;
    logic [OP_W-1:0] op_q;
    logic [7:0]      k_q;
    logic [10:0]     pc_q;
    logic [1:0]      page_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // An instruction write is accepted in this cycle.
    assign take = psel && penable && pready && pwrite && paddr == ADDR_INSTR;

    // Keeps the last instruction, the counter before it, and the page bits.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            op_q   <= OP_NOP;
            k_q    <= 8'h00;
            pc_q   <= 11'h000;
            page_q <= STATUS_RST[6:5];
        end
        else
        begin
            if (take)
            begin
                op_q <= pwdata[OP_LSB +: OP_W];
                k_q  <= pwdata[7:0];
                pc_q <= program_counter;
            end
            if (psel && penable && pready && pwrite && paddr == ADDR_STATUS)
                page_q <= pwdata[6:5];
        end
    end

    single_busy_a: assert property (
        take && pwdata[OP_LSB +: OP_W] != OP_CALL |=> exec_busy [*4] ##1 !exec_busy)
        else $error("single op busy length wrong");
    call_busy_a: assert property (
        take && pwdata[OP_LSB +: OP_W] == OP_CALL |=> exec_busy [*8] ##1 !exec_busy)
        else $error("call busy length wrong");
    call_low_a: assert property (
        $fell(exec_busy) && op_q == OP_CALL |-> program_counter[7:0] == k_q)
        else $error("call target not loaded");
    call_page_a: assert property (
        $fell(exec_busy) && op_q == OP_CALL |-> program_counter[10:8] == {page_q, 1'b0})
        else $error("call upper counter bits wrong");
    pc_step_a: assert property (
        $fell(exec_busy) && op_q != OP_CALL |-> program_counter == pc_q + 11'h001)
        else $error("counter did not step by one");
    write_stall_a: assert property (
        psel && pwrite && exec_busy |-> !pready)
        else $error("write accepted while busy");
    busy_start_a: assert property (
        $rose(exec_busy) |-> $past(take))
        else $error("busy rose without an instruction");
    pc_hold_a: assert property (
        exec_busy && $past(exec_busy) |-> $stable(program_counter))
        else $error("counter moved during execution");

    // Main scenarios reached.
    cover property (take && pwdata[OP_LSB +: OP_W] == OP_CALL);
    cover property (take && pwdata[OP_LSB +: OP_W] == OP_KICK_WDOG);
    cover property (psel && penable && pslverr);
endmodule

bind cio_exec_core cio_exec_checker cio_exec_checker_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .program_counter(program_counter),
    .exec_busy(exec_busy));

//--- verif/tb_cio_exec_core.sv
// Self-checking bench for the execution core, driven over APB.
// Assumes the checker binds itself; read expectations queue up for a monitor.
`timescale 1ns/100ps
module tb_cio_exec_core
    import cio_pkg::*;
;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [10:0] program_counter;
    logic        exec_busy;
    logic [32:0] exp_q[$];
    int          error_cnt;
    int          compares;

    cio_exec_core #(.STACK_DEPTH(4), .PSC_W(2), .WDOG_W(8)) cio_exec_core_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .program_counter(program_counter), .exec_busy(exec_busy));

    // Clock of 50 ns period.
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("counts: %0d compares, %0d mismatches", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // One APB transfer; the request holds until pready is seen high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
        begin
            error_cnt++;
            close_out();
        end
        else
        begin
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err = 1'b0);
        exp_q.push_back({err, e});
        apb(1'b0, a, 32'h0);
    endtask

    function automatic logic [7:0] fa(input logic [4:0] f);
        return {1'b1, f, 2'h0};
    endfunction

    // Issues an instruction, reads the accumulator mid-run, then writes the configuration; only a call stalls that write.
    task automatic exec(input logic [2:0] op, input logic d, input logic [7:0] k,
                        input logic [7:0] acc);
        apb(1'b1, ADDR_INSTR, {20'h0, op, d, k});
        rd(ADDR_ACC, {24'h0, acc});
        apb(1'b1, ADDR_CFG, 32'h0);
    endtask

    // Takes the oldest expectation whenever a read completes.
    always @(posedge pclk)
    begin
        if (psel && penable && pready && !pwrite && exp_q.size() > 0)
            check({pslverr, prdata}, exp_q.pop_front());
    end

    // Main sequence.
    initial
    begin
        logic [7:0]  v;
        logic [7:0]  r;
        logic [7:0]  a;
        logic [7:0]  s;
        logic [7:0]  k;
        logic [4:0]  f;
        logic [10:0] pc;
        logic [2:0]  op;
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        error_cnt = 0;
        compares  = 0;
        void'($urandom(8));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, ADDR_CFG, 32'h0);
        f = 5'h1F;
        apb(1'b1, ADDR_STATUS, 32'h0);
        apb(1'b1, ADDR_ACC, 32'h5A);
        apb(1'b1, fa(f), 32'hA5);
        exec(OP_ZERO_ACC, 1'b0, 8'h00, 8'h5A);
        rd(ADDR_ACC, 32'h0);
        rd(ADDR_STATUS, 32'h04);
        apb(1'b1, ADDR_STATUS, 32'h0);
        exec(OP_ZERO_FILE, 1'b0, {3'h0, f}, 8'h00);
        rd(fa(f), 32'h0);
        rd(ADDR_STATUS, 32'h04);
        $display("clear ops done");
        for (int i = 0; i < 15; i++)
        begin
            op = 3'(int'(OP_INVERT) + i % 3);
            f  = 5'($urandom);
            a  = 8'($urandom);
            s  = 8'($urandom) & 8'h63;
            v  = (i < 3) ? ((op == OP_MINUS_ONE) ? 8'h01 : 8'hFF) : (i < 6) ? 8'h00 : 8'($urandom);
            r  = (op == OP_INVERT) ? ~v : (op == OP_MINUS_ONE) ? v - 8'h01 : v + 8'h01;
            apb(1'b1, ADDR_STATUS, {24'h0, s | (r != 8'h00 ? 8'h04 : 8'h00)});
            apb(1'b1, ADDR_ACC, {24'h0, a});
            apb(1'b1, fa(f), {24'h0, v});
            exec(op, i[0], {3'h0, f}, a);
            rd(ADDR_ACC, {24'h0, i[0] ? a : r});
            rd(fa(f), {24'h0, i[0] ? r : v});
            rd(ADDR_STATUS, {24'h0, s | (r == 8'h00 ? 8'h04 : 8'h00)});
        end
        $display("file ops done");
        for (int i = 0; i < 5; i++)
        begin
            pc = (i == 0) ? 11'h7FF : 11'($urandom);
            k  = (i == 1) ? 8'hFF : 8'($urandom);
            s  = {1'b0, 2'($urandom), 5'h07};
            apb(1'b1, ADDR_STATUS, {24'h0, s});
            apb(1'b1, ADDR_PC, {21'h0, pc});
            apb(1'b1, ADDR_ACC, {24'h0, k});
            exec(OP_CALL, 1'b0, k, k);
            rd(ADDR_PC, {21'h0, s[6:5], 1'b0, k});
            rd(ADDR_STACK, {13'h0, 3'(i < 4 ? i + 1 : 4), 5'h0, pc + 11'h001});
            rd(ADDR_STATUS, {24'h0, s});
        end
        $display("call done");
        apb(1'b1, ADDR_CFG, 32'h2);
        repeat (10) @(posedge pclk);
        apb(1'b1, ADDR_CFG, 32'h0);
        apb(1'b1, ADDR_STATUS, 32'h63);
        exec(OP_KICK_WDOG, 1'b0, 8'h00, k);
        rd(ADDR_WDOG, 32'h0);
        rd(ADDR_STATUS, 32'h7B);
        exec(OP_NOP, 1'b0, 8'h00, k);
        // Kicks at shifted prescaler phases; a missed prescaler clear lets a tick through.
        for (int j = 0; j < 4; j++)
        begin
            apb(1'b1, ADDR_CFG, 32'h3);
            repeat (j) @(posedge pclk);
            exec(OP_KICK_WDOG, 1'b0, 8'h00, k);
            rd(ADDR_WDOG, 32'h0);
        end
        $display("watchdog kick done");
        rd(8'h1C, 32'h0, 1'b1);
        apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
        $display("unmapped access done");
        close_out();
    end
endmodule
